/* include/cpc_params.svh */
// Constants for the Cartesian to polar converter.
// Functional notes
// [RULE1] Takes 18-bit I and Q, computes vector magnitude and phase angle.
// [RULE2] Phase is 18 bits truncated; all to discriminator, top 16 to formatter.
// [RULE3] 16-bit phase scales angle by 1/(2*pi), valid signed or unsigned.
// [RULE4] Phase top bit weighs 180 degrees, each lower bit half the one above.
// [RULE5] Magnitude is 16-bit unsigned up to about 2.32, gain 1.64676 included.
// [RULE6] Magnitude bit 15 always zero; bit 13 is unity, bit 0 two to minus 13.
// [RULE7] Full precision takes 17 clocks, then results go to the holding register.
// [RULE8] A new sample before completion latches partial results and restarts.
// [RULE9] Each extra iteration roughly halves phase error, about 3.5 degrees at 6.
// [RULE10] FIR routing mode takes full 26-bit FIR I and Q, bypassing gain stage.
// [RULE11] Configuring party sets FIR routing select one, normal routing zero.
// [RULE12] With FIR routing, discriminator still gets top 18 phase bits.
// [RULE13] Capture gated by gain strobe, or resampler strobe when resampler enabled.
// [RULE14] Resampler bypassed: FIR data sampled 6 clocks after it becomes ready.
// [RULE15] Resampler enabled: strobe lags FIR ready by 6 plus resampler latency.
// [RULE16] Configuring party should bypass resampler when using FIR routing.
// [RULE17] Q zero select forces quadrature input to zero; magnitude of I alone.
// [RULE18] One-cycle result strobe each time a new result pair is latched.
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
`define CPC_IN_W 18
`define CPC_FIR_W 26
`define CPC_PAD_W 8
`define CPC_DP_W 28
`define CPC_PH_W 18
`define CPC_OUT_W 16
`define CPC_IT_W 4
`define CPC_ITER_LAST 4'hf
`define CPC_HALF_TURN 18'h20000
`define CPC_MAG_LSB 12
`endif

/* include/cpc_pkg.sv */
// Types for the Cartesian to polar converter.
`include "cpc_params.svh"
package cpc_pkg;
  typedef enum logic [1:0]
  {
    CPC_IDLE = 2'b00,
    CPC_RUN  = 2'b01
  } cpc_state_t;

  typedef struct packed
  {
    cpc_state_t                     state;
    logic [`CPC_IT_W-1:0]           iter;
    logic signed [`CPC_DP_W-1:0]    x;
    logic signed [`CPC_DP_W-1:0]    y;
    logic [`CPC_PH_W-1:0]           z;
    logic [`CPC_FIR_W-1:0]          fir_i;
    logic [`CPC_FIR_W-1:0]          fir_q;
    logic [`CPC_OUT_W-1:0]          mag;
    logic [`CPC_PH_W-1:0]           ph;
    logic                           vld;
  } cpc_regs_t;
endpackage : cpc_pkg

/* rtl/cpc_converter.sv */
// Iterative Cartesian to polar converter with early result latching.
`timescale 1ns/1ps
`include "cpc_params.svh"
module cpc_converter
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic [`CPC_IN_W-1:0]   agc_i,
  input  wire logic [`CPC_IN_W-1:0]   agc_q,
  input  wire logic                   agc_ready,
  input  wire logic [`CPC_IN_W-1:0]   rsmp_i,
  input  wire logic [`CPC_IN_W-1:0]   rsmp_q,
  input  wire logic                   rsmp_ready,
  input  wire logic                   rsmp_enable,
  input  wire logic [`CPC_FIR_W-1:0]  fir_i,
  input  wire logic [`CPC_FIR_W-1:0]  fir_q,
  input  wire logic                   fir_ready,
  input  wire logic                   fir_route,
  input  wire logic                   q_zero,
  output logic      [`CPC_OUT_W-1:0]  mag_out,
  output logic      [`CPC_PH_W-1:0]   phase_disc,
  output logic      [`CPC_OUT_W-1:0]  phase_fmt,
  output logic                        result_valid
);
  import cpc_pkg::*;

  cpc_regs_t                    st_r;
  cpc_regs_t                    st_nxt;
  logic                         rst_m_r;
  logic                         rst_n_r;
  logic                         strobe;
  logic                         busy;
  logic [`CPC_FIR_W-1:0]        src_i;
  logic [`CPC_FIR_W-1:0]        src_q;
  logic signed [`CPC_DP_W-1:0]  ld_i;
  logic signed [`CPC_DP_W-1:0]  ld_q;
  logic signed [`CPC_DP_W-1:0]  sx;
  logic signed [`CPC_DP_W-1:0]  sy;
  logic signed [`CPC_DP_W-1:0]  ix;
  logic signed [`CPC_DP_W-1:0]  iy;
  logic [`CPC_PH_W-1:0]         iz;

  // Arctangent of two to the minus k, in units of a full turn over 2^18.
  function automatic logic [`CPC_PH_W-1:0] cpc_atan
  (
    input logic [`CPC_IT_W-1:0] k
  );
    case (k)
      4'h0:    cpc_atan = 18'h08000;
      4'h1:    cpc_atan = 18'h04b90;
      4'h2:    cpc_atan = 18'h027ed;
      4'h3:    cpc_atan = 18'h01444;
      4'h4:    cpc_atan = 18'h00a2c;
      4'h5:    cpc_atan = 18'h00517;
      4'h6:    cpc_atan = 18'h0028c;
      4'h7:    cpc_atan = 18'h00146;
      4'h8:    cpc_atan = 18'h000a3;
      4'h9:    cpc_atan = 18'h00051;
      4'ha:    cpc_atan = 18'h00029;
      4'hb:    cpc_atan = 18'h00014;
      4'hc:    cpc_atan = 18'h0000a;
      4'hd:    cpc_atan = 18'h00005;
      4'he:    cpc_atan = 18'h00003;
      default: cpc_atan = 18'h00001;
    endcase
  endfunction : cpc_atan

  // Sign extends a 26-bit input word to the datapath width.
  function automatic logic signed [`CPC_DP_W-1:0] cpc_ext
  (
    input logic [`CPC_FIR_W-1:0] v
  );
    cpc_ext = {{(`CPC_DP_W-`CPC_FIR_W){v[`CPC_FIR_W-1]}}, v};
  endfunction : cpc_ext

  // Takes the 16-bit magnitude with bit 13 as unity and the top bit cleared.
  function automatic logic [`CPC_OUT_W-1:0] cpc_mag
  (
    input logic signed [`CPC_DP_W-1:0] x
  );
    cpc_mag = {1'b0, x[`CPC_DP_W-2:`CPC_MAG_LSB]}; // RULE5 RULE6
  endfunction : cpc_mag

  // Releases the reset through two flip-flops.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  assign busy   = (st_r.state == CPC_RUN);
  assign strobe = rsmp_enable ? rsmp_ready : agc_ready; // RULE13 RULE15

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    src_i = '0;
    src_q = '0;
    ld_i  = '0;
    ld_q  = '0;
    sx    = st_r.x >>> st_r.iter;
    sy    = st_r.y >>> st_r.iter;
    ix    = st_r.x;
    iy    = st_r.y;
    iz    = st_r.z;

    // FIR words are held from their ready pulse until the delayed strobe.
    if (fir_ready)
    begin
      st_nxt.fir_i = fir_i; // RULE14
      st_nxt.fir_q = fir_q;
    end

    // One rotation per clock drives the vector onto the positive x axis.
    if (busy)
    begin
      if (!st_r.y[`CPC_DP_W-1])
      begin
        ix = st_r.x + sy;
        iy = st_r.y - sx;
        iz = st_r.z + cpc_atan(st_r.iter); // RULE9
      end
      else
      begin
        ix = st_r.x - sy;
        iy = st_r.y + sx;
        iz = st_r.z - cpc_atan(st_r.iter); // RULE9
      end
      st_nxt.x    = ix;
      st_nxt.y    = iy;
      st_nxt.z    = iz;
      st_nxt.iter = st_r.iter + 4'h1;
      if (st_r.iter == `CPC_ITER_LAST)
      begin
        st_nxt.state = CPC_IDLE;
        st_nxt.mag   = cpc_mag(ix); // RULE7
        st_nxt.ph    = iz; // RULE2 RULE3 RULE4
        st_nxt.vld   = 1'b1; // RULE18
      end
    end

    if (strobe)
    begin
      // A sample arriving mid-conversion captures the refinement so far.
      if (busy)
      begin
        st_nxt.mag = cpc_mag(ix); // RULE8
        st_nxt.ph  = iz; // RULE8
        st_nxt.vld = 1'b1; // RULE18
      end
      if (fir_route)
      begin
        src_i = st_r.fir_i; // RULE10
        src_q = st_r.fir_q; // RULE10
      end
      else if (rsmp_enable)
      begin
        src_i = {rsmp_i, {`CPC_PAD_W{1'b0}}}; // RULE1
        src_q = {rsmp_q, {`CPC_PAD_W{1'b0}}};
      end
      else
      begin
        src_i = {agc_i, {`CPC_PAD_W{1'b0}}}; // RULE1
        src_q = {agc_q, {`CPC_PAD_W{1'b0}}};
      end
      if (q_zero)
      begin
        src_q = '0; // RULE17
      end
      ld_i = cpc_ext(src_i);
      ld_q = cpc_ext(src_q);
      // Vectors in the left half plane are turned by half a circle first.
      if (ld_i < 0)
      begin
        st_nxt.x = -ld_i;
        st_nxt.y = -ld_q;
        st_nxt.z = `CPC_HALF_TURN; // RULE4
      end
      else
      begin
        st_nxt.x = ld_i;
        st_nxt.y = ld_q;
        st_nxt.z = '0;
      end
      st_nxt.iter  = '0;
      st_nxt.state = CPC_RUN;
    end

    case (st_nxt.state)
      CPC_IDLE: st_nxt.state = CPC_IDLE;
      CPC_RUN:  st_nxt.state = CPC_RUN;
      default:  st_nxt.state = CPC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mag_out      = st_r.mag;
  assign phase_disc   = st_r.ph; // RULE2 RULE12
  assign phase_fmt    = st_r.ph[`CPC_PH_W-1:`CPC_PH_W-`CPC_OUT_W]; // RULE2 RULE3
  assign result_valid = st_r.vld;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_r);

  a_msb_zero: // RULE6
  assert property (result_valid |-> !mag_out[`CPC_OUT_W-1])
    else $error("Magnitude top bit is set.");

  a_phase_trunc: // RULE2
  assert property (phase_fmt == phase_disc[`CPC_PH_W-1:`CPC_PH_W-`CPC_OUT_W])
    else $error("Formatter phase is not the top of the discriminator phase.");

  a_full_done: // RULE7
  assert property ((busy && st_r.iter == `CPC_ITER_LAST && !strobe)
                   |=> (result_valid && !busy))
    else $error("Full conversion did not latch after its last iteration.");

  a_early_latch: // RULE8
  assert property ((strobe && busy) |=> (result_valid && busy && st_r.iter == '0))
    else $error("Early sample did not latch partial result and restart.");

  a_valid_cause: // RULE18
  assert property (result_valid |-> ($past(strobe && busy)
                   || $past(busy && st_r.iter == `CPC_ITER_LAST)))
    else $error("Result strobe without a latch event.");

  a_load_start: // RULE13
  assert property ((rsmp_enable ? rsmp_ready : agc_ready) |=> (busy && st_r.iter == '0))
    else $error("Selected ready strobe did not start a conversion.");

  a_q_zeroed: // RULE17
  assert property ((strobe && q_zero) |=> (st_r.y == '0))
    else $error("Quadrature input was not forced to zero.");

  a_mag_pos: // RULE5
  assert property ((busy && $past(busy)) |-> !st_r.x[`CPC_DP_W-1])
    else $error("Rotated vector left the right half plane.");

  a_fir_hold: // RULE14
  assert property (fir_ready |=> (st_r.fir_i == $past(fir_i)))
    else $error("FIR word was not held on its ready pulse.");

  // Results move only on a latch, and every load starts from a well formed vector.
  a_result_hold: // RULE7
  assert property (!result_valid |-> ($stable(mag_out) && $stable(phase_disc)))
    else $error("Results changed without a result strobe.");

  a_iter_step: // RULE7
  assert property ((busy && !strobe && st_r.iter != `CPC_ITER_LAST)
                   |=> (busy && st_r.iter == $past(st_r.iter) + 4'h1))
    else $error("Iteration count did not advance by one.");

  a_idle_quiet: // RULE18
  assert property ((!busy && !strobe) |=> (!busy && !result_valid))
    else $error("Idle converter started or strobed without a sample.");

  a_load_right: // RULE4
  assert property (strobe |=> (!st_r.x[`CPC_DP_W-1]
                   && (st_r.z == '0 || st_r.z == `CPC_HALF_TURN)))
    else $error("Loaded vector was not turned into the right half plane.");

  a_pad_zero: // RULE1
  assert property ((strobe && !fir_route) |=> (st_r.x[`CPC_PAD_W-1:0] == '0))
    else $error("Narrow input was not left aligned in the datapath.");

  a_fir_load: // RULE10
  assert property ((strobe && fir_route && !st_r.fir_i[`CPC_FIR_W-1])
                   |=> (st_r.x == cpc_ext($past(st_r.fir_i))))
    else $error("Held FIR word was not loaded in full.");

  a_q_kept: // RULE17
  assert property ((strobe && !q_zero && !fir_route && !rsmp_enable && agc_q != '0)
                   |=> (st_r.y != '0))
    else $error("Quadrature input was lost although not zeroed.");

  a_early_phase: // RULE8
  assert property ((strobe && busy) |=> (phase_disc == $past(iz)))
    else $error("Early latch did not keep the partial phase.");

  a_full_phase: // RULE2
  assert property ((busy && st_r.iter == `CPC_ITER_LAST && !strobe)
                   |=> (phase_disc == $past(iz)))
    else $error("Full conversion did not latch the final phase.");
endmodule : cpc_converter

/* test/cpc_upstream_model.sv */
// Behavioural model of the filter stages that feed the converter.
`timescale 1ns/1ps
module cpc_upstream_model
#(
  parameter int RSMP_LAT = 4
)
(
  input  wire logic        clock,
  input  wire logic        send,
  input  wire logic [25:0] i_val,
  input  wire logic [25:0] q_val,
  output logic      [25:0] fir_i,
  output logic      [25:0] fir_q,
  output logic             fir_ready,
  output logic      [17:0] agc_i,
  output logic      [17:0] agc_q,
  output logic             agc_ready,
  output logic      [17:0] rsmp_i,
  output logic      [17:0] rsmp_q,
  output logic             rsmp_ready
);
  logic [15:0] dly_r = 16'h0;

  always @(posedge clock)
  begin
    dly_r <= {dly_r[14:0], send};
  end

  assign fir_ready  = send;
  assign agc_ready  = dly_r[5];
  assign rsmp_ready = dly_r[5 + RSMP_LAT];
  // Data lines show the inverse of the word outside their strobe.
  assign fir_i  = send ? i_val : ~i_val;
  assign fir_q  = send ? q_val : ~q_val;
  assign agc_i  = agc_ready ? i_val[25:8] : ~i_val[25:8];
  assign agc_q  = agc_ready ? q_val[25:8] : ~q_val[25:8];
  // The resampler output is the swapped pair, so the chosen path is visible.
  assign rsmp_i = rsmp_ready ? q_val[25:8] : ~q_val[25:8];
  assign rsmp_q = rsmp_ready ? i_val[25:8] : ~i_val[25:8];
endmodule : cpc_upstream_model

/* test/cartesian_polar_converter_tb_top.sv */
// Self-checking testbench for the Cartesian to polar converter.
`timescale 1ns/1ps
module cartesian_polar_converter_tb_top;
  localparam int LAT = 4;
  logic        clock       = 1'b0;
  logic        reset_n     = 1'b0;
  logic        send        = 1'b0;
  logic        rsmp_enable = 1'b0;
  logic        fir_route   = 1'b0;
  logic        q_zero      = 1'b0;
  logic [25:0] i_val       = 26'h0;
  logic [25:0] q_val       = 26'h0;
  logic [25:0] fir_i, fir_q;
  logic [17:0] agc_i, agc_q, rsmp_i, rsmp_q, phase_disc;
  logic [15:0] mag_out, phase_fmt;
  logic        fir_ready, agc_ready, rsmp_ready, result_valid;
  int          n_fail      = 0;
  int          n_compared  = 0;

  cpc_upstream_model #(.RSMP_LAT(LAT)) i_cpc_upstream_model
  (
    .clock, .send, .i_val, .q_val, .fir_i, .fir_q, .fir_ready,
    .agc_i, .agc_q, .agc_ready, .rsmp_i, .rsmp_q, .rsmp_ready
  );

  cpc_converter i_cpc_converter
  (
    .clock, .reset_n, .agc_i, .agc_q, .agc_ready, .rsmp_i, .rsmp_q, .rsmp_ready,
    .rsmp_enable, .fir_i, .fir_q, .fir_ready, .fir_route, .q_zero,
    .mag_out, .phase_disc, .phase_fmt, .result_valid
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic pulse(input logic [25:0] i, input logic [25:0] q);
    i_val <= i;
    q_val <= q;
    send  <= 1'b1;
    @(posedge clock);
    send  <= 1'b0;
  endtask : pulse

  task automatic await(input int lat);
    int n;
    n = 1;
    while (result_valid !== 1'b1 && n < 60)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(n), 32'(lat));
  endtask : await

  task automatic judge();
    real         x, y, m, p;
    logic [17:0] e;
    x = $itor($signed(fir_route ? i_val : i_val & 26'h3ffff00));
    y = $itor($signed(fir_route ? q_val : q_val & 26'h3ffff00));
    if (rsmp_enable)
    begin
      m = x;
      x = y;
      y = m;
    end
    if (q_zero)
      y = 0.0;
    m = $sqrt(x * x + y * y) * 1.64676 / 4096.0;
    p = $atan2(y, x) * 41721.5;
    if (p < 0.0)
      p = p + 262144.0;
    e = phase_disc - 18'($rtoi(p));
    check(32'(mag_out[15]), 32'h0);
    check(32'(($itor(mag_out) - m) ** 2 < 36.0), 32'h1);
    check(32'(e + 18'h80 < 18'h100), 32'h1);
    check(32'(phase_fmt), 32'(phase_disc[17:2]));
    @(posedge clock);
    check(32'(result_valid), 32'h0);
  endtask : judge

  task automatic convert(input logic [25:0] i, input logic [25:0] q, input int lat);
    pulse(i, q);
    await(lat);
    judge();
  endtask : convert

  task automatic early_latch();
    pulse(26'h0c00000, 26'h0400000);
    repeat (4) @(posedge clock);
    pulse(26'h0c00000, 26'h0400000);
    await(8);
    check(32'(mag_out[15]), 32'h0);
    @(posedge clock);
    await(16);
    judge();
  endtask : early_latch

  initial
  begin
    forever #5 clock = ~clock;
  end

  initial
  begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    convert(26'h1000000, 26'h0, 24);
    convert(26'h0, 26'h1000000, 24);
    convert(26'h3000000, 26'h0, 24);
    convert(26'h0, 26'h3000000, 24);
    convert(26'h2000000, 26'h2000000, 24);
    convert(26'h0c00000, 26'h0400000, 24);
    q_zero <= 1'b1;
    convert(26'h0c00000, 26'h0400000, 24);
    q_zero    <= 1'b0;
    fir_route <= 1'b1;
    convert(26'h0008000, 26'h00000ff, 24);
    fir_route   <= 1'b0;
    rsmp_enable <= 1'b1;
    convert(26'h1000000, 26'h0400000, 24 + LAT);
    rsmp_enable <= 1'b0;
    early_latch();
    complete_run();
  end
endmodule : cartesian_polar_converter_tb_top
